// ### shared/qsr_pkg.sv
// Package for the questionable status register bank.
// Assumes one clock domain and a command port driven by the remote parser.
package qsr_pkg;
  localparam int unsigned NCH = 4;
  localparam int unsigned W = 16;
  // Group select codes
  localparam logic [1:0] GRP_TEMP = 2'h0;
  localparam logic [1:0] GRP_TIME = 2'h1;
  localparam logic [1:0] GRP_TRAN = 2'h2;
  // Part select codes
  localparam logic [2:0] PART_COND = 3'h0;
  localparam logic [2:0] PART_EVENT = 3'h1;
  localparam logic [2:0] PART_ENABLE = 3'h2;
  localparam logic [2:0] PART_PTR = 3'h3;
  localparam logic [2:0] PART_NTR = 3'h4;
  // Valid bit masks per group
  localparam logic [15:0] MASK_TEMP = 16'h0001;
  localparam logic [15:0] MASK_TIME = 16'h0002;
  localparam logic [15:0] MASK_TRAN = 16'h4fff;
  // Field positions
  localparam int unsigned TEMP_DEV_BIT = 0;
  localparam int unsigned TIME_SHORT_BIT = 1;
  localparam int unsigned TRAN_RANGE_LSB = 0;
  localparam int unsigned TRAN_NRANGE = 10;
  localparam int unsigned TRAN_IN1_BIT = 10;
  localparam int unsigned TRAN_IN2_BIT = 11;
  localparam int unsigned TRAN_EDGE_BIT = 14;
  // Preset values
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_PTR = 16'hffff;
  localparam logic [15:0] RST_NTR = 16'h0000;
  localparam logic [15:0] RST_EVENT = 16'h0000;
  localparam logic [15:0] RST_MASK_OTHER = 16'hffff;

  // Clearing actions decoded from the command stream
  typedef struct packed {
    logic power_on;
    logic psc;
    logic dev_clear;
    logic rst_preset;
    logic stat_preset;
    logic cls;
    logic pmt;
    logic cmd_start;
  } qsr_ctl_s;

  // Live status inputs for one channel
  typedef struct packed {
    logic warmup;
    logic temp_drift;
    logic sweep_short;
    logic [9:0] range_hit;
    logic in1;
    logic in2;
    logic at_edge;
  } qsr_live_s;

  // Register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] ch;
    logic [1:0] grp;
    logic [2:0] part;
    logic [15:0] data;
  } qsr_req_s;
endpackage : qsr_pkg

// ### core/qsr_group.sv
// One status register group: condition, event, enable and transition filters.
// Assumes the condition is resampled every cycle by the parent.
`timescale 1ns/1ns
module qsr_group #(
  parameter logic [15:0] VALID = 16'hffff
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] cond_in,
  input wire logic clr_event,
  input wire logic preset,
  input wire logic wr_en,
  input wire logic [2:0] wr_part,
  input wire logic [15:0] wr_data,
  input wire logic rd_event,
  output logic [15:0] cond,
  output logic [15:0] event_q,
  output logic [15:0] enable,
  output logic [15:0] ptr,
  output logic [15:0] ntr
);
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] hit;
  logic [15:0] next_event;
  logic wr_enable;
  logic wr_ptr;
  logic wr_ntr;

  assign rise = cond_in & ~cond;
  assign fall = ~cond_in & cond;
  assign hit = ((rise & ptr) | (fall & ntr)) & VALID;
  // New hits win over a clear or a read-clear in the same cycle
  assign next_event = ((clr_event | rd_event) ? qsr_pkg::RST_EVENT : event_q) | hit;
  assign wr_enable = wr_en && (wr_part == qsr_pkg::PART_ENABLE);
  assign wr_ptr = wr_en && (wr_part == qsr_pkg::PART_PTR);
  assign wr_ntr = wr_en && (wr_part == qsr_pkg::PART_NTR);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cond <= 16'h0000;
      event_q <= qsr_pkg::RST_EVENT;
    end else begin
      cond <= cond_in & VALID;
      event_q <= next_event;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable <= qsr_pkg::RST_ENABLE;
      ptr <= qsr_pkg::RST_PTR;
      ntr <= qsr_pkg::RST_NTR;
    end else if (preset) begin
      enable <= qsr_pkg::RST_ENABLE;
      ptr <= qsr_pkg::RST_PTR;
      ntr <= qsr_pkg::RST_NTR;
    end else begin
      if (wr_enable) enable <= wr_data & VALID;
      if (wr_ptr) ptr <= wr_data & VALID;
      if (wr_ntr) ntr <= wr_data & VALID;
    end
  end
endmodule : qsr_group

// ### core/qsr_bank.sv
// Questionable status bank: temperature, sweep time and transducer groups.
// Assumes the command parser decodes clearing actions into single-cycle pulses.
`timescale 1ns/1ns
module qsr_bank (
  input wire logic clk,
  input wire logic sys_rst,
  input wire qsr_pkg::qsr_ctl_s ctl,
  input wire qsr_pkg::qsr_live_s [qsr_pkg::NCH-1:0] live,
  input wire logic [qsr_pkg::NCH-1:0] ch_active,
  input wire qsr_pkg::qsr_req_s req,
  input wire logic continue_measurement,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [qsr_pkg::NCH-1:0] break_pending,
  output logic sweep_resume,
  output logic clr_status_byte,
  output logic clr_srq_masks,
  output logic clr_error_queue,
  output logic flush_output,
  output logic flush_input,
  output logic settings_reset
);
  localparam int unsigned NG = 3;
  typedef enum logic [1:0] {
    QSR_IDLE = 2'b01,
    QSR_ARMED = 2'b10
  } qsr_flush_e;

  qsr_flush_e flush_state;
  qsr_flush_e next_flush_state;
  logic psc_on;
  logic full_clear;
  logic do_preset;
  logic clr_events;
  logic hard_flush;
  logic deferred;
  logic flush_now;
  logic [15:0] cond_vec [qsr_pkg::NCH][NG];
  logic [15:0] ev_vec [qsr_pkg::NCH][NG];
  logic [15:0] en_vec [qsr_pkg::NCH][NG];
  logic [15:0] pt_vec [qsr_pkg::NCH][NG];
  logic [15:0] nt_vec [qsr_pkg::NCH][NG];
  logic [15:0] sel_data;
  logic [15:0] sel_cond;
  logic [15:0] sel_event;
  logic [15:0] sel_enable;
  logic [15:0] sel_ptr;
  logic [15:0] sel_ntr;
  logic rd_hit;
  logic [qsr_pkg::NCH-1:0] edge_seen;
  logic [qsr_pkg::NCH-1:0] next_break;

  assign psc_on = ctl.power_on & ctl.psc;
  assign full_clear = ctl.cls | psc_on;
  assign do_preset = ctl.stat_preset | psc_on;
  assign clr_events = full_clear;
  assign hard_flush = ctl.power_on | ctl.dev_clear;
  assign deferred = ctl.rst_preset | ctl.stat_preset | ctl.cls;
  // Compare at three bits so a channel count of four is not cut to zero
  assign rd_hit = req.rd && (req.grp != 2'h3) && ({1'b0, req.ch} < 3'(qsr_pkg::NCH));

  genvar c;
  generate
    for (c = 0; c < qsr_pkg::NCH; c++) begin : g_ch
      logic [15:0] temp_c;
      logic [15:0] time_c;
      logic [15:0] tran_c;
      logic wr_c;
      logic rd_c;
      logic act;

      assign act = ch_active[c];
      always_comb begin
        temp_c = 16'h0000;
        temp_c[qsr_pkg::TEMP_DEV_BIT] = act & (live[c].temp_drift | live[c].warmup);
      end
      always_comb begin
        time_c = 16'h0000;
        time_c[qsr_pkg::TIME_SHORT_BIT] = act & live[c].sweep_short;
      end
      always_comb begin
        tran_c = 16'h0000;
        tran_c[qsr_pkg::TRAN_RANGE_LSB +: qsr_pkg::TRAN_NRANGE] =
          act ? live[c].range_hit : 10'h000;
        tran_c[qsr_pkg::TRAN_IN1_BIT] = act & live[c].in1;
        tran_c[qsr_pkg::TRAN_IN2_BIT] = act & live[c].in2;
        tran_c[qsr_pkg::TRAN_EDGE_BIT] = act & live[c].at_edge;
      end

      assign wr_c = req.wr && (req.ch == 2'(c));
      assign rd_c = req.rd && (req.ch == 2'(c)) && (req.part == qsr_pkg::PART_EVENT);

      qsr_group #(.VALID(qsr_pkg::MASK_TEMP)) u_temp (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond_in(temp_c),
        .clr_event(clr_events),
        .preset(do_preset),
        .wr_en(wr_c && (req.grp == qsr_pkg::GRP_TEMP)),
        .wr_part(req.part),
        .wr_data(req.data),
        .rd_event(rd_c && (req.grp == qsr_pkg::GRP_TEMP)),
        .cond(cond_vec[c][0]),
        .event_q(ev_vec[c][0]),
        .enable(en_vec[c][0]),
        .ptr(pt_vec[c][0]),
        .ntr(nt_vec[c][0])
      );
      qsr_group #(.VALID(qsr_pkg::MASK_TIME)) u_time (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond_in(time_c),
        .clr_event(clr_events),
        .preset(do_preset),
        .wr_en(wr_c && (req.grp == qsr_pkg::GRP_TIME)),
        .wr_part(req.part),
        .wr_data(req.data),
        .rd_event(rd_c && (req.grp == qsr_pkg::GRP_TIME)),
        .cond(cond_vec[c][1]),
        .event_q(ev_vec[c][1]),
        .enable(en_vec[c][1]),
        .ptr(pt_vec[c][1]),
        .ntr(nt_vec[c][1])
      );
      qsr_group #(.VALID(qsr_pkg::MASK_TRAN)) u_tran (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond_in(tran_c),
        .clr_event(clr_events),
        .preset(do_preset),
        .wr_en(wr_c && (req.grp == qsr_pkg::GRP_TRAN)),
        .wr_part(req.part),
        .wr_data(req.data),
        .rd_event(rd_c && (req.grp == qsr_pkg::GRP_TRAN)),
        .cond(cond_vec[c][2]),
        .event_q(ev_vec[c][2]),
        .enable(en_vec[c][2]),
        .ptr(pt_vec[c][2]),
        .ntr(nt_vec[c][2])
      );

      // Break raised on changeover edge, held until host continues
      assign edge_seen[c] = act & live[c].at_edge;
      assign next_break[c] = edge_seen[c] | (break_pending[c] & ~continue_measurement);
    end
  endgenerate

  assign sel_cond = cond_vec[req.ch][req.grp];
  assign sel_event = ev_vec[req.ch][req.grp];
  assign sel_enable = en_vec[req.ch][req.grp];
  assign sel_ptr = pt_vec[req.ch][req.grp];
  assign sel_ntr = nt_vec[req.ch][req.grp];

  always_comb begin
    unique case (req.part)
      qsr_pkg::PART_COND: sel_data = sel_cond;
      qsr_pkg::PART_EVENT: sel_data = sel_event;
      qsr_pkg::PART_ENABLE: sel_data = sel_enable;
      qsr_pkg::PART_PTR: sel_data = sel_ptr;
      qsr_pkg::PART_NTR: sel_data = sel_ntr;
      default: sel_data = 16'h0000;
    endcase
  end

  // Deferred output buffer flush after reset-type commands
  always_comb begin
    next_flush_state = flush_state;
    flush_now = 1'b0;
    unique case (flush_state)
      QSR_IDLE: begin
        if (deferred) next_flush_state = QSR_ARMED;
      end
      QSR_ARMED: begin
        if (ctl.cmd_start && ctl.pmt) begin
          flush_now = 1'b1;
          next_flush_state = QSR_IDLE;
        end
      end
      default: next_flush_state = QSR_IDLE;
    endcase
    if (hard_flush) next_flush_state = QSR_IDLE;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_state <= QSR_IDLE;
    end else begin
      flush_state <= next_flush_state;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      break_pending <= '0;
      sweep_resume <= 1'b0;
    end else begin
      rd_data <= rd_hit ? (sel_data & 16'h7fff) : 16'h0000;
      rd_valid <= req.rd;
      break_pending <= next_break;
      sweep_resume <= continue_measurement & (|break_pending);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_status_byte <= 1'b0;
      clr_srq_masks <= 1'b0;
      clr_error_queue <= 1'b0;
      flush_output <= 1'b0;
      flush_input <= 1'b0;
      settings_reset <= 1'b0;
    end else begin
      clr_status_byte <= full_clear;
      clr_srq_masks <= psc_on;
      clr_error_queue <= full_clear | ctl.power_on;
      flush_output <= hard_flush | flush_now;
      flush_input <= hard_flush;
      settings_reset <= ctl.rst_preset;
    end
  end
endmodule : qsr_bank

// ### verification/qsr_bank_chk.sv
// Port checker for the questionable status bank.
// Assumes binding onto qsr_bank, one clock domain.
`timescale 1ns/1ns
module qsr_bank_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire qsr_pkg::qsr_ctl_s ctl,
  input wire qsr_pkg::qsr_live_s [qsr_pkg::NCH-1:0] live,
  input wire logic [qsr_pkg::NCH-1:0] ch_active,
  input wire qsr_pkg::qsr_req_s req,
  input wire logic continue_measurement,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic [qsr_pkg::NCH-1:0] break_pending,
  input wire logic sweep_resume,
  input wire logic clr_status_byte,
  input wire logic clr_srq_masks,
  input wire logic clr_error_queue,
  input wire logic flush_output,
  input wire logic flush_input,
  input wire logic settings_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (req.rd |=> rd_valid)
    else $error("read not answered");
  a_idle_read: assert property (!req.rd |=> !rd_valid && rd_data == 16'h0000)
    else $error("read data without read");
  a_top_bit: assert property (rd_data[15] == 1'b0)
    else $error("bit 15 set");
  a_cls_clear: assert property (ctl.cls || ctl.power_on && ctl.psc |=> clr_status_byte)
    else $error("status byte not cleared");
  a_srq_clear: assert property (clr_srq_masks |-> $past(ctl.power_on && ctl.psc))
    else $error("mask clear without cause");
  a_err_clear: assert property (ctl.power_on || ctl.cls |=> clr_error_queue)
    else $error("error queue not cleared");
  a_flush_in: assert property (ctl.power_on || ctl.dev_clear |=> flush_input && flush_output)
    else $error("buffers not flushed");
  a_flush_cause: assert property (flush_output |-> $past(ctl.power_on | ctl.dev_clear | ctl.cmd_start & ctl.pmt))
    else $error("output flush without cause");
  a_settings_keep: assert property (settings_reset |-> $past(ctl.rst_preset))
    else $error("settings reset without cause");
  a_break_set: assert property (ch_active[0] && live[0].at_edge |=> break_pending[0])
    else $error("break not flagged");
  a_resume: assert property (sweep_resume |-> $past(continue_measurement))
    else $error("resume without continue");
  a_resume_set: assert property (continue_measurement && |break_pending |=> sweep_resume)
    else $error("sweep not resumed");
  a_srq_set: assert property (ctl.power_on && ctl.psc |=> clr_srq_masks)
    else $error("masks not cleared");
  a_settings_set: assert property (ctl.rst_preset |=> settings_reset)
    else $error("settings reset missing");
endmodule : qsr_bank_chk
bind qsr_bank qsr_bank_chk i_chk (.*);

// ### verification/qsr_host_model.sv
// Remote host stand-in answering a break with continue_measurement.
// Assumes break_pending is a registered level from the bank.
`timescale 1ns/1ns
module qsr_host_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [qsr_pkg::NCH-1:0] break_pending,
  output logic continue_measurement
);
  initial begin
    continue_measurement = 1'b0;
    forever begin
      @(negedge clk);
      if (|break_pending) begin
        repeat (slow ? 6 : 1) @(negedge clk);
        continue_measurement = 1'b1;
        @(negedge clk);
        continue_measurement = 1'b0;
      end
    end
  end
endmodule : qsr_host_model

// ### verification/qsr_bank_bench.sv
// Self-checking bench for the questionable status bank.
// Assumes the checker is bound and the host model answers breaks.
`timescale 1ns/1ns
module qsr_bank_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic slow = 1'b0;
  qsr_pkg::qsr_ctl_s ctl = '0;
  qsr_pkg::qsr_live_s [qsr_pkg::NCH-1:0] live = '0;
  logic [qsr_pkg::NCH-1:0] ch_active = 4'hf;
  qsr_pkg::qsr_req_s req = '0;
  logic cont, rd_valid, sweep_resume, flush_output;
  logic [15:0] rd_data, lv, e;
  logic [qsr_pkg::NCH-1:0] break_pending;
  logic [1:0] c;
  int n_fail = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  qsr_bank i_dut (
    .clk(clk), .sys_rst(sys_rst), .ctl(ctl), .live(live), .ch_active(ch_active),
    .req(req), .continue_measurement(cont), .rd_data(rd_data), .rd_valid(rd_valid),
    .break_pending(break_pending), .sweep_resume(sweep_resume), .clr_status_byte(),
    .clr_srq_masks(), .clr_error_queue(), .flush_output(flush_output), .flush_input(),
    .settings_reset()
  );
  qsr_host_model i_host (
    .clk(clk), .slow(slow), .break_pending(break_pending), .continue_measurement(cont)
  );
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [1:0] ch, g, input logic [2:0] p,
                     input logic [15:0] d);
    @(negedge clk);
    req = '{rd: !w, wr: w, ch: ch, grp: g, part: p, data: d};
    @(negedge clk);
    req = '0;
  endtask : acc
  task automatic rd(input logic [1:0] ch, g, input logic [2:0] p, input logic [15:0] x);
    acc(1'b0, ch, g, p, 16'h0000);
    chk({15'h0, rd_valid}, 16'h0001);
    chk(rd_data, x);
  endtask : rd
  task automatic pulse(input qsr_pkg::qsr_ctl_s m);
    @(negedge clk);
    ctl = ctl | m;
    @(negedge clk);
    ctl = ctl & ~m;
  endtask : pulse
  function automatic logic [15:0] cond_of(input qsr_pkg::qsr_live_s l, input logic [1:0] g);
    case (g)
      qsr_pkg::GRP_TEMP: return {15'h0, l.warmup | l.temp_drift};
      qsr_pkg::GRP_TIME: return {14'h0, l.sweep_short, 1'b0};
      default: return {1'b0, l.at_edge, 2'b00, l.in2, l.in1, l.range_hit};
    endcase
  endfunction : cond_of
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(29));
    repeat (20) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    for (int g = 0; g < 3; g++) begin
      rd(2'h0, g[1:0], qsr_pkg::PART_ENABLE, 16'h0000);
      rd(2'h0, g[1:0], qsr_pkg::PART_PTR, 16'h7fff);
      rd(2'h0, g[1:0], qsr_pkg::PART_NTR, 16'h0000);
    end
    for (int k = 0; k < 16; k++) begin
      c = k[1:0];
      slow = k[2];
      ch_active = (k < 4) ? 4'hf : 4'($urandom);
      live[c] = '0;
      repeat (3) @(negedge clk);
      for (int g = 0; g < 3; g++) acc(1'b0, c, g[1:0], qsr_pkg::PART_EVENT, 16'h0000);
      lv = (k == 0) ? 16'hffff : (k == 1) ? 16'h8000 : 16'($urandom);
      live[c] = lv;
      repeat (3) @(negedge clk);
      for (int g = 0; g < 3; g++) begin
        e = ch_active[c] ? cond_of(lv, g[1:0]) : 16'h0000;
        rd(c, g[1:0], qsr_pkg::PART_COND, e);
        rd(c, g[1:0], qsr_pkg::PART_EVENT, e);
        rd(c, g[1:0], qsr_pkg::PART_EVENT, 16'h0000);
      end
    end
    live = '0;
    ch_active = 4'hf;
    acc(1'b1, 2'h1, qsr_pkg::GRP_TRAN, qsr_pkg::PART_ENABLE, 16'hffff);
    rd(2'h1, qsr_pkg::GRP_TRAN, qsr_pkg::PART_ENABLE, qsr_pkg::MASK_TRAN);
    pulse('{rst_preset: 1'b1, default: 1'b0});
    pulse('{dev_clear: 1'b1, default: 1'b0});
    rd(2'h1, qsr_pkg::GRP_TRAN, qsr_pkg::PART_ENABLE, qsr_pkg::MASK_TRAN);
    ctl.pmt = 1'b1;
    pulse('{stat_preset: 1'b1, default: 1'b0});
    chk({15'h0, flush_output}, 16'h0000);
    pulse('{cmd_start: 1'b1, default: 1'b0});
    chk({15'h0, flush_output}, 16'h0001);
    rd(2'h1, qsr_pkg::GRP_TRAN, qsr_pkg::PART_ENABLE, 16'h0000);
    acc(1'b1, 2'h2, qsr_pkg::GRP_TEMP, qsr_pkg::PART_PTR, 16'h0000);
    acc(1'b1, 2'h2, qsr_pkg::GRP_TEMP, qsr_pkg::PART_NTR, 16'hffff);
    live[2].temp_drift = 1'b1;
    repeat (3) @(negedge clk);
    rd(2'h2, qsr_pkg::GRP_TEMP, qsr_pkg::PART_EVENT, 16'h0000);
    live[2].temp_drift = 1'b0;
    repeat (3) @(negedge clk);
    rd(2'h2, qsr_pkg::GRP_TEMP, qsr_pkg::PART_EVENT, 16'h0001);
    live[3].in1 = 1'b1;
    repeat (3) @(negedge clk);
    pulse('{cls: 1'b1, default: 1'b0});
    rd(2'h3, qsr_pkg::GRP_TRAN, qsr_pkg::PART_EVENT, 16'h0000);
    pulse('{power_on: 1'b1, default: 1'b0});
    pulse('{power_on: 1'b1, psc: 1'b1, default: 1'b0});
    rd(2'h2, qsr_pkg::GRP_TEMP, qsr_pkg::PART_PTR, 16'h7fff);
    rd(2'h2, qsr_pkg::GRP_TEMP, qsr_pkg::PART_NTR, 16'h0000);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      live[0].at_edge = 1'b1;
      @(negedge clk);
      live[0].at_edge = 1'b0;
      chk({15'h0, break_pending[0]}, 16'h0001);
      for (int i = 0; i < 20 && break_pending[0] !== 1'b0; i++) @(negedge clk);
      chk({15'h0, break_pending[0]}, 16'h0000);
    end
    wrap_up();
  end
endmodule : qsr_bank_bench
